/* inc/threshold_pkg.sv */
// Purpose: Shared constants for the spectral threshold and status block.
// Assumes: One 25 MHz core clock, synchronous active-high reset.
// Notes: Offsets are the register addresses seen by the serial host.
//
// Notes on behaviour
// - High threshold is one 16-bit value: low byte register plus high byte.
// - Both high threshold byte registers are read/write and reset to zero.
// - Selected channel above high threshold after persistence raises the event.
// - Three-bit channel select, reset 0, picks channel 0 to 4 for comparison.
// - Status bit 1 reads high while waiting for a sync pulse to start.
// - Status bit 0 reads 0 while busy and 1 once measurement is ready.
// - Interrupt flags clear on write of 1; writing 0 leaves them alone.
// - Flag bit 3 sets on a qualifying threshold event when enabled.
// - Flag bit 2 sets while FIFO level meets threshold; re-arms on new data.
// - Flag bit 1 marks calibration, bit 0 system events; both reset 0.
// - Second status bit 6 sets when a measurement has completed.
// - Second status bit 4 shows the integration counter reached its maximum.
// - Second status bit 3 shows the analog front end saturated.
// - Third status bit 5 records an above-high-threshold cause.
// - Third status bit 4 records a below-low-threshold cause.
// - Selected channel below low threshold after persistence raises the event.
// - Excursion must persist for the set count of consecutive measurements.
// - Low threshold low byte is latched and applied with the high byte write.
package threshold_pkg;

    localparam logic [7:0] ADDR_MEAS_STATE = 8'h71;
    localparam logic [7:0] ADDR_LOW_TH_LO = 8'h84;
    localparam logic [7:0] ADDR_LOW_TH_HI = 8'h85;
    localparam logic [7:0] ADDR_HIGH_TH_LO = 8'h86;
    localparam logic [7:0] ADDR_HIGH_TH_HI = 8'h87;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h93;
    localparam logic [7:0] ADDR_SAT_VALID = 8'ha3;
    localparam logic [7:0] ADDR_CAUSE = 8'ha4;
    localparam logic [7:0] ADDR_CH_SEL = 8'hb5;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] TH_RESET = 16'h0000;
    localparam logic [2:0] CH_SEL_RESET = 3'h0;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    localparam int BIT_READY = 0;
    localparam int BIT_WAIT_SYNC = 1;
    localparam int BIT_SYS = 0;
    localparam int BIT_CAL = 1;
    localparam int BIT_FIFO = 2;
    localparam int BIT_SPEC = 3;
    localparam int BIT_FE_SAT = 3;
    localparam int BIT_CNT_SAT = 4;
    localparam int BIT_VALID = 6;
    localparam int BIT_BELOW = 4;
    localparam int BIT_ABOVE = 5;

    localparam int CH_COUNT = 5;
    localparam int CH_SEL_W = 3;
    localparam int TH_W = 16;
    localparam int PERSIST_W = 4;
    localparam int IRQ_W = 4;
    localparam logic [3:0] I2C_BITS = 4'h8;

endpackage

/* inc/reg_access_if.sv */
// Purpose: Register access carrier between the serial target and registers.
// Assumes: All signals on mclk; wr is a one-cycle pulse.
// Notes: rdata is combinational from addr.
`timescale 1ns/1ps
interface reg_access_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    modport master
    (
        output addr,
        output wdata,
        output wr,
        input rdata
    );
    modport target
    (
        input addr,
        input wdata,
        input wr,
        output rdata
    );
endinterface

/* logic/i2c_target.sv */
// Purpose: Serial two-wire target that turns bus transfers into register
//          reads and writes with an auto-incrementing pointer.
// Assumes: scl and sda come from pins; mclk much faster than scl.
// Notes: First written byte after the address sets the pointer.
`timescale 1ns/1ps
module i2c_target
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_oe,
    reg_access_if.master bus
);

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_MACK = 5'h10
    } i2c_state_t;

    i2c_state_t state;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_last;
    logic sda_last;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] txd;
    logic [7:0] ptr;
    logic is_addr;
    logic first;
    logic rw;
    logic nack;
    logic scl_now;
    logic sda_now;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    ////////////////////////////////////////////////////////////////////////
    // Pins pass two flip-flops; edges are taken from the second stage only.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_last <= 1'b1;
            sda_last <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda_in};
            scl_last <= scl_sync[1];
            sda_last <= sda_sync[1];
        end
    end

    assign scl_now = scl_sync[1];
    assign sda_now = sda_sync[1];
    assign scl_rise = scl_now & ~scl_last;
    assign scl_fall = ~scl_now & scl_last;
    assign start_cond = scl_now & scl_last & sda_last & ~sda_now;
    assign stop_cond = scl_now & scl_last & ~sda_last & sda_now;
    assign bus.addr = ptr;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk)
    begin
        bus.wr <= 1'b0;
        if (rst)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            txd <= 8'h00;
            ptr <= 8'h00;
            is_addr <= 1'b0;
            first <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            bus.wdata <= 8'h00;
        end
        else
        begin
            // The pointer moves on the cycle after a write has used it.
            if (bus.wr)
                ptr <= ptr + 8'h01;
            if (start_cond)
            begin
                state <= ST_RECV;
                cnt <= 4'h0;
                is_addr <= 1'b1;
                sda_oe <= 1'b0;
            end
            else if (stop_cond)
            begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    ST_RECV:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sda_now};
                            cnt <= cnt + 4'h1;
                        end
                        else if (scl_fall && cnt == threshold_pkg::I2C_BITS)
                        begin
                            if (is_addr)
                            begin
                                if (shreg[7:1] == DEVICE_ADDR)
                                begin
                                    rw <= shreg[0];
                                    first <= ~shreg[0];
                                    sda_oe <= 1'b1;
                                    state <= ST_ACK;
                                end
                                else
                                    state <= ST_IDLE;
                            end
                            else
                            begin
                                sda_oe <= 1'b1;
                                state <= ST_ACK;
                                if (first)
                                begin
                                    ptr <= shreg;
                                    first <= 1'b0;
                                end
                                else
                                begin
                                    bus.wdata <= shreg;
                                    bus.wr <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            cnt <= 4'h0;
                            if (rw)
                            begin
                                txd <= bus.rdata;
                                sda_oe <= ~bus.rdata[7];
                                state <= ST_SEND;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                is_addr <= 1'b0;
                                state <= ST_RECV;
                            end
                        end
                    end
                    ST_SEND:
                    begin
                        if (scl_rise)
                            cnt <= cnt + 4'h1;
                        else if (scl_fall)
                        begin
                            if (cnt == threshold_pkg::I2C_BITS)
                            begin
                                sda_oe <= 1'b0;
                                ptr <= ptr + 8'h01;
                                state <= ST_MACK;
                            end
                            else
                            begin
                                txd <= {txd[6:0], 1'b0};
                                sda_oe <= ~txd[6];
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                            nack <= sda_now;
                        else if (scl_fall)
                        begin
                            cnt <= 4'h0;
                            if (nack)
                                state <= ST_IDLE;
                            else
                            begin
                                txd <= bus.rdata;
                                sda_oe <= ~bus.rdata[7];
                                state <= ST_SEND;
                            end
                        end
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

/* logic/threshold_check.sv */
// Purpose: Compares one channel sample against the thresholds and filters
//          excursions by a consecutive-measurement count.
// Assumes: sample_valid is a one-cycle pulse per finished measurement.
// Notes: A persistence of 0 fires on the first excursion.
`timescale 1ns/1ps
module threshold_check
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [threshold_pkg::TH_W-1:0] sample,
    input wire logic [threshold_pkg::TH_W-1:0] high_th,
    input wire logic [threshold_pkg::TH_W-1:0] low_th,
    input wire logic [threshold_pkg::PERSIST_W-1:0] persist,
    output logic above_event,
    output logic below_event
);

    logic [threshold_pkg::PERSIST_W-1:0] run;
    logic [threshold_pkg::PERSIST_W-1:0] next_run;
    logic above;
    logic below;

    assign above = sample > high_th;
    assign below = sample < low_th;
    // The run count saturates so a long excursion keeps firing.
    assign next_run = (&run) ? run : run + 1'b1;

    always_ff @(posedge mclk)
    begin
        above_event <= 1'b0;
        below_event <= 1'b0;
        if (rst)
            run <= '0;
        else if (sample_valid)
        begin
            if (above || below)
            begin
                run <= next_run;
                if (next_run >= persist)
                begin
                    above_event <= above;
                    below_event <= below;
                end
            end
            else
                run <= '0;
        end
    end

endmodule

/* logic/spectral_threshold_status.sv */
// Purpose: Threshold registers, channel select and device status flags,
//          reached by the host over the two-wire serial bus.
// Assumes: Engine signals are on mclk; scl and sda are pins.
// Notes: Interrupt flags are write-1-to-clear; a set in the clear cycle wins.
`timescale 1ns/1ps
module spectral_threshold_status
#(
    // Bus address value is arbitrary.
    parameter logic [6:0] DEVICE_ADDR = 7'h2a
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [threshold_pkg::CH_COUNT-1:0][15:0] channel_data,
    input wire logic measurement_ready,
    input wire logic waiting_for_sync,
    input wire logic measurement_start,
    input wire logic measurement_done,
    input wire logic counter_saturated,
    input wire logic frontend_saturated,
    input wire logic spectral_irq_enable,
    input wire logic fifo_irq_enable,
    input wire logic system_irq_enable,
    input wire logic [threshold_pkg::PERSIST_W-1:0] persistence_count,
    input wire logic [7:0] fifo_fill_level,
    input wire logic [7:0] fifo_trigger_level,
    input wire logic calibration_event,
    input wire logic system_event,
    output logic [threshold_pkg::IRQ_W-1:0] interrupt_flags,
    output logic [threshold_pkg::CH_SEL_W-1:0] threshold_channel_select
);

    reg_access_if bus ();

    logic [7:0] low_threshold_low_byte;
    logic [7:0] high_threshold_low_byte;
    logic [threshold_pkg::TH_W-1:0] low_threshold;
    logic [threshold_pkg::TH_W-1:0] high_threshold;
    logic measurement_valid;
    logic counter_sat_flag;
    logic frontend_sat_flag;
    logic above_high_cause;
    logic below_low_cause;
    logic [7:0] fifo_level_last;
    logic fifo_met_last;
    logic fifo_met;
    logic fifo_set;
    logic spec_set;
    logic above_event;
    logic below_event;
    logic sel_ok;
    logic [threshold_pkg::TH_W-1:0] sample;
    logic [threshold_pkg::IRQ_W-1:0] irq_set;
    logic [threshold_pkg::IRQ_W-1:0] irq_clr;
    logic [threshold_pkg::IRQ_W-1:0] next_irq;
    logic wr_flags;

    assign sda_out = 1'b0;

    i2c_target #(.DEVICE_ADDR(DEVICE_ADDR)) serial
    (
        .mclk(mclk),
        .rst(rst),
        .scl(scl),
        .sda_in(sda_in),
        .sda_oe(sda_oe),
        .bus(bus.master)
    );

    ////////////////////////////////////////////////////////////////////////
    // Threshold bytes. A low byte waits in its latch until the high byte
    // is written, so the comparator never sees a half-updated threshold.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            low_threshold_low_byte <= threshold_pkg::REG_RESET;
            high_threshold_low_byte <= threshold_pkg::REG_RESET;
            low_threshold <= threshold_pkg::TH_RESET;
            high_threshold <= threshold_pkg::TH_RESET;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                threshold_pkg::ADDR_LOW_TH_LO:
                    low_threshold_low_byte <= bus.wdata;
                threshold_pkg::ADDR_LOW_TH_HI:
                    low_threshold <= {bus.wdata, low_threshold_low_byte};
                threshold_pkg::ADDR_HIGH_TH_LO:
                    high_threshold_low_byte <= bus.wdata;
                threshold_pkg::ADDR_HIGH_TH_HI:
                    high_threshold <= {bus.wdata, high_threshold_low_byte};
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            threshold_channel_select <= threshold_pkg::CH_SEL_RESET;
        else if (bus.wr && bus.addr == threshold_pkg::ADDR_CH_SEL)
            threshold_channel_select <= bus.wdata[threshold_pkg::CH_SEL_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Select codes above the last channel compare nothing and raise nothing.
    assign sel_ok = threshold_channel_select < 3'(threshold_pkg::CH_COUNT);
    assign sample = sel_ok ? channel_data[threshold_channel_select] : '0;

    threshold_check check
    (
        .mclk(mclk),
        .rst(rst),
        .sample_valid(measurement_done & sel_ok),
        .sample(sample),
        .high_th(high_threshold),
        .low_th(low_threshold),
        .persist(persistence_count),
        .above_event(above_event),
        .below_event(below_event)
    );

    ////////////////////////////////////////////////////////////////////////
    // FIFO flag re-arms when the level rises; an empty FIFO never sets it.
    assign fifo_met = (fifo_fill_level >= fifo_trigger_level)
        && (fifo_fill_level != 8'h00);
    assign fifo_set = fifo_irq_enable && fifo_met
        && (!fifo_met_last || fifo_fill_level > fifo_level_last);

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fifo_level_last <= 8'h00;
            fifo_met_last <= 1'b0;
        end
        else
        begin
            fifo_level_last <= fifo_fill_level;
            fifo_met_last <= fifo_met;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags. Writing back what was read clears only serviced
    // events; anything that sets in the same cycle survives the clear.
    assign spec_set = spectral_irq_enable & (above_event | below_event);
    assign wr_flags = bus.wr && bus.addr == threshold_pkg::ADDR_IRQ_FLAGS;
    assign irq_clr = wr_flags ? bus.wdata[threshold_pkg::IRQ_W-1:0] : '0;

    always_comb
    begin
        irq_set = '0;
        irq_set[threshold_pkg::BIT_SPEC] = spec_set;
        irq_set[threshold_pkg::BIT_FIFO] = fifo_set;
        irq_set[threshold_pkg::BIT_CAL] = calibration_event;
        irq_set[threshold_pkg::BIT_SYS] = system_irq_enable & system_event;
        next_irq = (interrupt_flags & ~irq_clr) | irq_set;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            interrupt_flags <= threshold_pkg::IRQ_RESET;
        else
            interrupt_flags <= next_irq;
    end

    // Cause flags follow the spectral flag: cleared with it, set first.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            above_high_cause <= 1'b0;
            below_low_cause <= 1'b0;
        end
        else
        begin
            if (spec_set && above_event)
                above_high_cause <= 1'b1;
            else if (irq_clr[threshold_pkg::BIT_SPEC])
                above_high_cause <= 1'b0;
            if (spec_set && below_event)
                below_low_cause <= 1'b1;
            else if (irq_clr[threshold_pkg::BIT_SPEC])
                below_low_cause <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement flags hold from completion or saturation until the next start.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            measurement_valid <= 1'b0;
            counter_sat_flag <= 1'b0;
            frontend_sat_flag <= 1'b0;
        end
        else
        begin
            if (measurement_done)
                measurement_valid <= 1'b1;
            else if (measurement_start)
                measurement_valid <= 1'b0;
            if (counter_saturated)
                counter_sat_flag <= 1'b1;
            else if (measurement_start)
                counter_sat_flag <= 1'b0;
            if (frontend_saturated)
                frontend_sat_flag <= 1'b1;
            else if (measurement_start)
                frontend_sat_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data; unmapped addresses and reserved bits read as zero.
    always_comb
    begin
        bus.rdata = threshold_pkg::REG_RESET;
        case (bus.addr)
            threshold_pkg::ADDR_MEAS_STATE:
            begin
                bus.rdata[threshold_pkg::BIT_READY] = measurement_ready;
                bus.rdata[threshold_pkg::BIT_WAIT_SYNC] = waiting_for_sync;
            end
            threshold_pkg::ADDR_LOW_TH_LO:
                bus.rdata = low_threshold_low_byte;
            threshold_pkg::ADDR_LOW_TH_HI:
                bus.rdata = low_threshold[15:8];
            threshold_pkg::ADDR_HIGH_TH_LO:
                bus.rdata = high_threshold_low_byte;
            threshold_pkg::ADDR_HIGH_TH_HI:
                bus.rdata = high_threshold[15:8];
            threshold_pkg::ADDR_IRQ_FLAGS:
                bus.rdata[threshold_pkg::IRQ_W-1:0] = interrupt_flags;
            threshold_pkg::ADDR_SAT_VALID:
            begin
                bus.rdata[threshold_pkg::BIT_VALID] = measurement_valid;
                bus.rdata[threshold_pkg::BIT_CNT_SAT] = counter_sat_flag;
                bus.rdata[threshold_pkg::BIT_FE_SAT] = frontend_sat_flag;
            end
            threshold_pkg::ADDR_CAUSE:
            begin
                bus.rdata[threshold_pkg::BIT_ABOVE] = above_high_cause;
                bus.rdata[threshold_pkg::BIT_BELOW] = below_low_cause;
            end
            threshold_pkg::ADDR_CH_SEL:
                bus.rdata[threshold_pkg::CH_SEL_W-1:0] = threshold_channel_select;
            default:
                bus.rdata = threshold_pkg::REG_RESET;
        endcase
    end

endmodule

/* tb/sts_monitor.sv */
// Purpose: Port checks for spectral_threshold_status.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Flags and select may only drop or move during a bus acknowledge.
`timescale 1ns/1ps
module sts_monitor (input wire logic mclk, rst, sda_oe, measurement_done,
    system_irq_enable, calibration_event, system_event,
    input wire logic [threshold_pkg::IRQ_W-1:0] interrupt_flags,
    input wire logic [threshold_pkg::CH_SEL_W-1:0] threshold_channel_select);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_sel_rst; disable iff (1'b0)
        rst |=> threshold_channel_select == 3'h0; endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("sel rst");
    property p_flg_rst; disable iff (1'b0)
        rst |=> interrupt_flags == 4'h0; endproperty
    a_flg_rst: assert property (p_flg_rst) else $error("flg rst");
    property p_cal; calibration_event |=> interrupt_flags[1]; endproperty
    a_cal: assert property (p_cal) else $error("cal set");
    property p_sys;
        system_event && system_irq_enable |=> interrupt_flags[0]; endproperty
    a_sys: assert property (p_sys) else $error("sys set");
    property p_sys_src; $rose(interrupt_flags[0])
        |-> $past(system_event && system_irq_enable); endproperty
    a_sys_src: assert property (p_sys_src) else $error("sys src");
    // The compare is registered, so the flag trails the measurement by two.
    property p_spec;
        $rose(interrupt_flags[3]) |-> $past(measurement_done, 2); endproperty
    a_spec: assert property (p_spec) else $error("spec src");
    property p_w1c; !$past(rst) &&
        ($past(interrupt_flags) & ~interrupt_flags) != 4'h0 |-> sda_oe;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag drop");
    property p_sel_wr;
        !$past(rst) && $changed(threshold_channel_select) |-> sda_oe;
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("sel move");
endmodule
bind spectral_threshold_status sts_monitor sts_monitor_inst (.*);

/* tb/i2c_host_model.sv */
// Purpose: Two-wire bus host that performs register writes and reads.
// Assumes: Pull-up on the data line; pins move after mclk falling edges.
// Notes: Each phase lasts six mclk, above the four-cycle minimum.
`timescale 1ns/1ps
module i2c_host_model #(parameter logic [6:0] ADDR = 7'h2a)
(
    input wire logic mclk,
    input wire logic sda_oe,
    output logic scl = 1'b1,
    output logic sda_in
);
    logic rel = 1'b1;
    // A released line floats high through the pull-up.
    assign sda_in = rel & ~sda_oe;
    task automatic ph(input logic s, input logic c);
        rel = s;
        scl = c;
        repeat (6) @(negedge mclk);
    endtask
    // Data is set with the clock low, then flips with the clock high: start for 1, stop for 0.
    task automatic frame(input logic a);
        ph(rel, 1'b0);
        ph(a, 1'b0);
        ph(a, 1'b1);
        ph(~a, 1'b1);
    endtask
    task automatic xfer(input logic [8:0] d, output logic [7:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            ph(rel, 1'b0);
            ph(d[i], 1'b0);
            ph(d[i], 1'b1);
            if (i > 0) q[i-1] = sda_in;
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] p,
        input logic [7:0] d, output logic [7:0] q);
        frame(1'b1);
        xfer({ADDR, 2'b01}, q);
        xfer({p, 1'b1}, q);
        if (w)
            xfer({d, 1'b1}, q);
        else
        begin
            frame(1'b1);
            xfer({ADDR, 2'b11}, q);
            xfer(9'h1ff, q);
        end
        frame(1'b0);
    endtask
endmodule

/* tb/spectral_threshold_status_tb.sv */
// Purpose: Self-checking bench for spectral_threshold_status.
// Assumes: Bus traffic comes from the host model; inputs move at negedge.
// Notes: Channel 2 is selected, so channel 0 data must be ignored.
`timescale 1ns/1ps
module spectral_threshold_status_tb;
    logic mclk = 1'b0, rst = 1'b1, done = 1'b0, ev = 1'b0, st = 1'b0;
    logic scl, sda_in, sda_oe;
    logic [threshold_pkg::CH_COUNT-1:0][15:0] ch = '0;
    logic [3:0] pers = 4'h0, flags;
    logic [7:0] lvl = 8'h00, q;
    logic [7:0] regs [8] = '{8'h71, 8'h86, 8'h87, 8'h93, 8'ha3, 8'ha4,
        8'hb5, 8'h10};
    logic [2:0] sel;
    int n_fail = 0, n_checks = 0;
    initial forever #20 mclk = ~mclk;
    spectral_threshold_status spectral_threshold_status_inst (.mclk, .rst,
        .scl, .sda_in, .sda_out(), .sda_oe, .channel_data(ch),
        .measurement_ready(st), .waiting_for_sync(st),
        .measurement_start(1'b0), .measurement_done(done),
        .counter_saturated(st), .frontend_saturated(st),
        .spectral_irq_enable(1'b1), .fifo_irq_enable(1'b1),
        .system_irq_enable(1'b1), .persistence_count(pers),
        .fifo_fill_level(lvl), .fifo_trigger_level(8'h04),
        .calibration_event(ev), .system_event(ev),
        .interrupt_flags(flags), .threshold_channel_select(sel));
    i2c_host_model i2c_host_model_inst (.mclk, .sda_oe, .scl, .sda_in);
    task automatic chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, e);
        i2c_host_model_inst.acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, d);
        i2c_host_model_inst.acc(1'b1, a, d, q);
    endtask
    task automatic meas(input int n);
        repeat (n)
        begin
            done = 1'b1;
            @(negedge mclk);
            done = 1'b0;
            repeat (3) @(negedge mclk);
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        foreach (regs[i])
            rc(regs[i], 8'h00);
        wr(8'h86, 8'h34);
        rc(8'h86, 8'h34);
        rc(8'h87, 8'h00);
        wr(8'h87, 8'h12);
        wr(8'hb5, 8'h02);
        chk({5'h0, sel}, 8'h02);
        ch[0] = 16'hffff;
        ch[2] = 16'h1234;
        meas(1);
        chk({4'h0, flags}, 8'h00);
        ch[2] = 16'h1235;
        meas(1);
        chk({4'h0, flags}, 8'h08);
        rc(8'ha4, 8'h20);
        wr(8'h93, 8'h08);
        rc(8'h93, 8'h00);
        wr(8'h85, 8'h10);
        pers = 4'h2;
        ch[2] = 16'h1100;
        meas(1);
        ch[2] = 16'h0fff;
        meas(1);
        chk({4'h0, flags}, 8'h00);
        meas(2);
        chk({4'h0, flags}, 8'h08);
        rc(8'ha4, 8'h10);
        ev = 1'b1;
        @(negedge mclk);
        ev = 1'b0;
        wr(8'h93, 8'h08);
        rc(8'h93, 8'h03);
        lvl = 8'h04;
        repeat (2) @(negedge mclk);
        chk({4'h0, flags}, 8'h07);
        st = 1'b1;
        @(negedge mclk);
        rc(8'ha3, 8'h58);
        rc(8'h71, 8'h03);
        close_out();
    end
endmodule
